// File: hw/uart_irq_status_line_format.v
// interrupt source reporting and line format control of a serial transceiver
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "uart_fmt_consts.vh"

// How it works
// - six priority levels; a read returns the highest pending code
// - a read clears only the reported source; lower ones show later
// - the reported source stays latched until serviced by a read
// - line status is top priority, code 000110
// - data available reads 000100, data timeout reads 001100, priority two
// - holding empty is priority three 000010; modem status priority four 000000
// - xoff or special char priority five 010000; flow change priority six 100000
// - bits 7:6 read 11 with fifos enabled, else 00, default 00
// - bits 5:4 sources report only while feature bit 4 is set
// - xoff-detect stays set until matching xon characters arrive
// - bit 0 reads 0 while pending, 1 when idle, default 1
// - format bit 7 opens divisor latch and feature register access
// - format bit 6 holds serial output low until cleared
// - forced parity: 1 when bit 4 is 0, 0 when bit 4 is 1
// - unforced parity: bit 4 0 gives odd, 1 gives even
// - bit 3 enables parity append on transmit and check on receive
// - bit 2 selects stop length together with word length, default 0
// - stop 0 gives one; 1 gives 1.5 for five bits, else two
// - bits 1:0 set character length for transmit and receive
// - length code 00..11 selects 5..8 data bits
module uart_irq_status_line_format
(
  // clock and reset
  input  wire       core_clk_i,
  input  wire       arst_n_i,
  // register port
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // interrupt events from neighbouring units, one-cycle pulses
  input  wire       line_status_event_i,
  input  wire       rx_data_available_event_i,
  input  wire       rx_timeout_event_i,
  input  wire       tx_holding_empty_event_i,
  input  wire       modem_status_event_i,
  input  wire       xoff_detect_event_i,
  input  wire       xon_detect_event_i,
  input  wire       flow_change_event_i,
  // transmitter serial path
  input  wire       tx_serial_i,
  output reg        tx_serial_o,
  // format to transmitter and receiver
  output reg  [3:0] data_bits_o,
  output reg  [2:0] stop_half_bits_o,
  output reg        parity_en_o,
  output reg        parity_forced_o,
  output reg        parity_forced_val_o,
  output reg        parity_even_o,
  output reg        divisor_access_o,
  output reg        fifo_enable_o,
  output reg        irq_pending_o
);

  // ****************************************
  // state
  // ****************************************
  reg  [7:0]          line_format_reg;
  reg  [7:0]          enhanced_feature_reg;
  reg  [`NUM_SRC-1:0] pend;
  reg                 xoff_state;

  wire [`NUM_SRC-1:0] grant;
  wire [5:0]          code;
  wire                any;
  wire [`NUM_SRC-1:0] evt;
  wire [`NUM_SRC-1:0] visible;
  wire [`NUM_SRC-1:0] clr;
  wire                enh;
  wire                isr_rd;
  wire [7:0]          isr_val;

  reg  [7:0]          next_rdata;
  reg  [2:0]          next_stop;

  // ****************************************
  // register select, decoded in several places
  // ****************************************
  function sel;
    input [2:0] a;
    input [2:0] ofs;
    sel = (a == ofs);
  endfunction

  assign enh = enhanced_feature_reg[`FEAT_ENH_BIT];
  // feature register shares the offset of the source register behind the latch bit
  assign isr_rd = rd_i && sel(addr_i, `OFS_INT_SOURCE) && !line_format_reg[`LF_DLAB_BIT];

  assign evt[`SRC_LINE_STATUS] = line_status_event_i;
  assign evt[`SRC_RX_DATA]     = rx_data_available_event_i;
  assign evt[`SRC_RX_TIMEOUT]  = rx_timeout_event_i;
  assign evt[`SRC_TX_EMPTY]    = tx_holding_empty_event_i;
  assign evt[`SRC_MODEM]       = modem_status_event_i;
  assign evt[`SRC_XOFF]        = xoff_detect_event_i;
  assign evt[`SRC_FLOW]        = flow_change_event_i;

  // ****************************************
  // pending flags; set wins over the read clear
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1)
    begin : pend_bits
      always @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          pend[g] <= 1'b0;
        else if (evt[g])
          pend[g] <= 1'b1;
        else if (clr[g])
          pend[g] <= 1'b0;
      end
    end
  endgenerate

  // xoff-detect is not cleared by the read, only by xon
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      xoff_state <= 1'b0;
    else if (xoff_detect_event_i)
      xoff_state <= 1'b1;
    else if (xon_detect_event_i)
      xoff_state <= 1'b0;
  end

  // upper sources masked unless enhanced features are on
  assign visible = {pend[`SRC_FLOW] & enh,
                    (pend[`SRC_XOFF] | xoff_state) & enh,
                    pend[`SRC_MODEM:`SRC_LINE_STATUS]};

  irq_priority_pick u_pick
  (
    .pend_i  (visible),
    .grant_o (grant),
    .code_o  (code),
    .any_o   (any)
  );

  // only the source shown by the read is cleared
  // clearing the live winner keeps the read data and the clear in step
  assign clr = isr_rd ? grant : {`NUM_SRC{1'b0}};

  assign isr_val = {{2{fifo_enable_o}},
                    code[5:1],
                    ~any};

  // ****************************************
  // register writes
  // ****************************************
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      line_format_reg <= `LINE_FORMAT_RESET;
    else if (wr_i && sel(addr_i, `OFS_LINE_FORMAT))
      line_format_reg <= wdata_i;
  end

  // feature register sits behind the latch bit
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      enhanced_feature_reg <= `FEATURE_RESET;
    else if (wr_i && sel(addr_i, `OFS_FEATURE) && line_format_reg[`LF_DLAB_BIT])
      enhanced_feature_reg <= wdata_i;
  end

  // fifo control shares the offset while the latch bit is clear
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fifo_enable_o <= `FIFO_EN_RESET;
    else if (wr_i && sel(addr_i, `OFS_FIFO_CTRL) && !line_format_reg[`LF_DLAB_BIT])
      fifo_enable_o <= wdata_i[`FIFO_EN_BIT];
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  always @*
  begin
    next_rdata = 8'h00;
    if (sel(addr_i, `OFS_LINE_FORMAT))
      next_rdata = line_format_reg;
    else if (sel(addr_i, `OFS_INT_SOURCE))
      next_rdata = line_format_reg[`LF_DLAB_BIT] ? enhanced_feature_reg : isr_val;
    else if (sel(addr_i, `OFS_STATUS))
      next_rdata = {7'h00, xoff_state};
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end

  // ****************************************
  // format outputs
  // ****************************************
  always @*
  begin
    if (!line_format_reg[`LF_STOP_BIT])
      next_stop = `STOP_HALF_ONE;
    else if (line_format_reg[`LF_LEN_HI:`LF_LEN_LO] == 2'h0)
      next_stop = `STOP_HALF_ONE_HALF;
    else
      next_stop = `STOP_HALF_TWO;
  end

  // ****************************************
  // character and stop length
  // ****************************************
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      data_bits_o <= `DATA_BITS_MIN;
    else
      data_bits_o <= `DATA_BITS_MIN + {2'h0, line_format_reg[`LF_LEN_HI:`LF_LEN_LO]};
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stop_half_bits_o <= `STOP_HALF_ONE;
    else
      stop_half_bits_o <= next_stop;
  end

  // ****************************************
  // parity
  // ****************************************
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      parity_en_o <= 1'b0;
    else
      parity_en_o <= line_format_reg[`LF_PAR_EN_BIT];
  end

  // forcing only counts while parity is enabled
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      parity_forced_o <= 1'b0;
    else
      parity_forced_o <= line_format_reg[`LF_PAR_EN_BIT] & line_format_reg[`LF_FORCE_BIT];
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      parity_forced_val_o <= `FORCED_VAL_RESET;
    else
      parity_forced_val_o <= ~line_format_reg[`LF_EVEN_BIT];
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      parity_even_o <= 1'b0;
    else
      parity_even_o <= line_format_reg[`LF_EVEN_BIT];
  end

  // ****************************************
  // latch access, break and interrupt level
  // ****************************************
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      divisor_access_o <= 1'b0;
    else
      divisor_access_o <= line_format_reg[`LF_DLAB_BIT];
  end

  // break forces the line low; held until software clears the bit
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tx_serial_o <= `TX_IDLE;
    else
      tx_serial_o <= tx_serial_i & ~line_format_reg[`LF_BREAK_BIT];
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_pending_o <= 1'b0;
    else
      irq_pending_o <= any;
  end

endmodule

// File: hw/uart_fmt_consts.vh
// constants for the interrupt source and line format block
`ifndef UART_FMT_CONSTS_VH
`define UART_FMT_CONSTS_VH

// ****************************************
// register offsets (plain port, 3-bit address)
// ****************************************
`define OFS_INT_SOURCE      3'h2
`define OFS_LINE_FORMAT     3'h3
`define OFS_FIFO_CTRL       3'h2
`define OFS_FEATURE         3'h2
`define OFS_STATUS          3'h5

// ****************************************
// line format fields
// ****************************************
`define LF_DLAB_BIT         7
`define LF_BREAK_BIT        6
`define LF_FORCE_BIT        5
`define LF_EVEN_BIT         4
`define LF_PAR_EN_BIT       3
`define LF_STOP_BIT         2
`define LF_LEN_HI           1
`define LF_LEN_LO           0
`define LINE_FORMAT_RESET   8'h00
`define FEATURE_RESET       8'h00
`define FIFO_EN_RESET       1'h0
`define DATA_BITS_MIN       4'h5
`define FORCED_VAL_RESET    1'h1
`define TX_IDLE             1'h1

// ****************************************
// feature and fifo control fields
// ****************************************
`define FEAT_ENH_BIT        4
`define FIFO_EN_BIT         0

// ****************************************
// interrupt source codes, bits 5:0
// ****************************************
`define CODE_NONE           6'h01
`define CODE_LINE_STATUS    6'h06
`define CODE_RX_DATA        6'h04
`define CODE_RX_TIMEOUT     6'h0C
`define CODE_TX_EMPTY       6'h02
`define CODE_MODEM          6'h00
`define CODE_XOFF           6'h10
`define CODE_FLOW           6'h20
`define INT_SOURCE_RESET    8'h01

// ****************************************
// source indices, highest priority first
// ****************************************
`define NUM_SRC             7
`define SRC_LINE_STATUS     0
`define SRC_RX_DATA         1
`define SRC_RX_TIMEOUT      2
`define SRC_TX_EMPTY        3
`define SRC_MODEM           4
`define SRC_XOFF            5
`define SRC_FLOW            6

// ****************************************
// stop length in half bit times
// ****************************************
`define STOP_HALF_ONE       3'h2
`define STOP_HALF_ONE_HALF  3'h3
`define STOP_HALF_TWO       3'h4

`endif

// File: hw/irq_priority_pick.v
// fixed-priority picker for pending interrupt sources
`timescale 1ns/1ps
`include "uart_fmt_consts.vh"

module irq_priority_pick
(
  // pending sources, index 0 highest
  input  wire [`NUM_SRC-1:0] pend_i,
  // winning source
  output reg  [`NUM_SRC-1:0] grant_o,
  output reg  [5:0]          code_o,
  output reg                 any_o
);

  integer k;

  // ****************************************
  // first set bit wins
  // ****************************************
  always @*
  begin
    grant_o = {`NUM_SRC{1'b0}};
    any_o   = 1'b0;
    for (k = 0; k < `NUM_SRC; k = k + 1)
    begin
      if (pend_i[k] && !any_o)
      begin
        grant_o[k] = 1'b1;
        any_o      = 1'b1;
      end
    end
  end

  always @*
  begin
    case (grant_o)
      7'h01:   code_o = `CODE_LINE_STATUS;
      7'h02:   code_o = `CODE_RX_DATA;
      7'h04:   code_o = `CODE_RX_TIMEOUT;
      7'h08:   code_o = `CODE_TX_EMPTY;
      7'h10:   code_o = `CODE_MODEM;
      7'h20:   code_o = `CODE_XOFF;
      7'h40:   code_o = `CODE_FLOW;
      default: code_o = `CODE_NONE;
    endcase
  end

endmodule

// File: verif/uart_fmt_chk.sv
// assertion checker for the interrupt source and line format block
`timescale 1ns/1ps
module uart_fmt_chk
(
  // clock and reset
  input wire       core_clk_i,
  input wire       arst_n_i,
  // register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  // events and serial path
  input wire       line_status_event_i,
  input wire       tx_serial_i,
  input wire       tx_serial_o,
  // format outputs
  input wire [3:0] data_bits_o,
  input wire [2:0] stop_half_bits_o,
  input wire       parity_en_o,
  input wire       parity_forced_o,
  input wire       parity_forced_val_o,
  input wire       parity_even_o,
  input wire       divisor_access_o,
  input wire       irq_pending_o
);
  reg [7:0] lf;
  reg       fe;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // shadow copies; outputs lag them by one cycle
  always @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      lf <= 8'h00;
      fe <= 1'b0;
    end
    else if (wr_i && addr_i == 3'h3)
      lf <= wdata_i;
    else if (wr_i && addr_i == 3'h2 && !lf[7])
      fe <= wdata_i[0];
  a_len_map: assert property (data_bits_o == 4'h5 + $past(lf[1:0]))
    else $error("data bits out of step with format");
  a_stop_len: assert property (stop_half_bits_o == (!$past(lf[2]) ? 3'h2 :
    ($past(lf[1:0]) == 2'h0) ? 3'h3 : 3'h4)) else $error("stop length wrong");
  a_break_gate: assert property (tx_serial_o ==
    ($past(lf[6]) ? 1'b0 : $past(tx_serial_i))) else $error("serial output wrong");
  a_parity_map: assert property (parity_en_o == $past(lf[3]) &&
    parity_forced_o == ($past(lf[5]) && $past(lf[3])) && parity_even_o == $past(lf[4]) &&
    parity_forced_val_o == !$past(lf[4])) else $error("parity outputs wrong");
  a_latch_open: assert property (divisor_access_o == $past(lf[7]))
    else $error("divisor access wrong");
  a_fifo_bits: assert property ($past(rd_i && addr_i == 3'h2 && !lf[7]) |->
    rdata_o[7:6] == {2{$past(fe)}}) else $error("fifo bits wrong");
  a_code_legal: assert property ($past(rd_i && addr_i == 3'h2 && !lf[7]) |->
    rdata_o[5:0] inside {6'h01, 6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20})
    else $error("source code not legal");
  a_fmt_read: assert property ($past(rd_i && addr_i == 3'h3) |-> rdata_o == $past(lf))
    else $error("format readback wrong");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_top_pend: assert property (line_status_event_i |-> ##2 irq_pending_o)
    else $error("line status not pending");
endmodule
bind uart_irq_status_line_format uart_fmt_chk i_uart_fmt_chk (.*);

// File: verif/tx_line_src.sv
// serial source standing in for the transmitter feeding the break gate
`timescale 1ns/1ps
module tx_line_src
(
  // clock and reset
  input  wire core_clk_i,
  input  wire arst_n_i,
  // serial bit toward the block
  output reg  tx_serial_o
);
  reg [6:0] lfsr;
  // bit changes often so a stuck or late copy shows up
  always @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      lfsr        <= 7'h5A;
      tx_serial_o <= 1'b1;
    end
    else
    begin
      lfsr        <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      tx_serial_o <= lfsr[0];
    end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the interrupt source and line format block
`timescale 1ns/1ps
module tb_top;
  reg         core_clk;
  reg         arst_n;
  reg  [2:0]  addr;
  reg  [7:0]  wdata;
  reg         wr;
  reg         rd;
  reg  [7:0]  ev;
  wire [7:0]  rdata;
  wire        tx_in;
  wire        tx_out;
  wire [3:0]  data_bits;
  wire [2:0]  stop_half;
  wire [4:0]  fmt;
  wire        fifo_en;
  wire        irq;
  wire [41:0] codes = {6'h20, 6'h10, 6'h00, 6'h02, 6'h0C, 6'h04, 6'h06};
  integer     n_fail;
  integer     checks;
  integer     i;
  integer     k;
  reg  [7:0]  lf;
  reg  [6:0]  m;
  always #12.5 core_clk = ~core_clk;
  tx_line_src i_tx_line_src (.core_clk_i(core_clk), .arst_n_i(arst_n), .tx_serial_o(tx_in));
  uart_irq_status_line_format i_uart_irq_status_line_format
  (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .line_status_event_i(ev[0]),
    .rx_data_available_event_i(ev[1]), .rx_timeout_event_i(ev[2]),
    .tx_holding_empty_event_i(ev[3]), .modem_status_event_i(ev[4]),
    .xoff_detect_event_i(ev[5]), .flow_change_event_i(ev[6]), .xon_detect_event_i(ev[7]),
    .tx_serial_i(tx_in), .tx_serial_o(tx_out), .data_bits_o(data_bits),
    .stop_half_bits_o(stop_half), .parity_en_o(fmt[4]), .parity_forced_o(fmt[3]),
    .parity_forced_val_o(fmt[2]), .parity_even_o(fmt[1]), .divisor_access_o(fmt[0]),
    .fifo_enable_o(fifo_en), .irq_pending_o(irq)
  );
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
    end
  endtask
  task rdc(input [2:0] a, input [7:0] exp);
    begin
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
    end
  endtask
  task pulse(input [7:0] v);
    begin
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 8'h00;
    end
  endtask
  task feat(input [7:0] v);
    begin
      wr_reg(3'h3, 8'h80);
      wr_reg(3'h2, v);
      rdc(3'h2, v);
      wr_reg(3'h3, 8'h00);
    end
  endtask
  function [2:0] stop_of(input [7:0] f);
    stop_of = !f[2] ? 3'h2 : (f[1:0] == 2'h0) ? 3'h3 : 3'h4;
  endfunction
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // watchdog: a hang counts as a mismatch
  initial
  begin
    #2000000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    {core_clk, arst_n, addr, wdata, wr, rd, ev} = 0;
    n_fail = 0;
    checks = 0;
    k = $urandom(6830);
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk("bits", 8'h05, data_bits);
    chk("stop", 8'h02, stop_half);
    rdc(3'h2, 8'h01);
    rdc(3'h3, 8'h00);
    rdc(3'h7, 8'h00);
    feat(8'h10);
    for (i = 0; i < 7; i = i + 1)
    begin
      pulse(8'h01 << i);
      @(posedge core_clk);
      #1 chk("irq", 8'h01, irq);
      rdc(3'h2, {2'b00, codes[6*i +: 6]});
      pulse(8'h80);
      rdc(3'h2, 8'h01);
      chk("irq", 8'h00, irq);
    end
    pulse(8'h20);
    rdc(3'h5, 8'h01);
    rdc(3'h2, 8'h10);
    rdc(3'h5, 8'h01);
    pulse(8'h80);
    rdc(3'h5, 8'h00);
    pulse(8'h10);
    pulse(8'h01);
    rdc(3'h2, 8'h06);
    rdc(3'h2, 8'h00);
    rdc(3'h2, 8'h01);
    // read in the cycle right after the event must clear what it reports
    @(posedge core_clk);
    ev   <= 8'h08;
    @(posedge core_clk);
    ev   <= 8'h00;
    addr <= 3'h2;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk("rdata", 8'h02, rdata);
    rdc(3'h2, 8'h01);
    for (k = 0; k < 20; k = k + 1)
    begin
      m = $urandom;
      pulse({1'b0, m});
      for (i = 0; i < 7; i = i + 1)
        if (m[i])
        begin
          rdc(3'h2, {2'b00, codes[6*i +: 6]});
          pulse(8'h80);
        end
      rdc(3'h2, 8'h01);
    end
    feat(8'h00);
    pulse(8'h60);
    rdc(3'h2, 8'h01);
    pulse(8'h80);
    wr_reg(3'h2, 8'h01);
    #1 chk("fifo", 8'h01, fifo_en);
    rdc(3'h2, 8'hC1);
    wr_reg(3'h2, 8'h00);
    // first four are the stop length corners for each word length
    for (k = 0; k < 24; k = k + 1)
    begin
      lf = (k < 4) ? {6'h01, k[1:0]} : $urandom;
      wr_reg(3'h3, lf);
      @(posedge core_clk);
      #1 chk("bits", 8'h05 + lf[1:0], data_bits);
      chk("stop", stop_of(lf), stop_half);
      chk("fmt", {lf[3], lf[5] & lf[3], !lf[4], lf[4], lf[7]}, fmt);
      if (lf[6])
        chk("tx", 8'h00, tx_out);
      rdc(3'h3, lf);
    end
    wr_reg(3'h3, 8'h00);
    print_verdict;
  end
endmodule
